// ### hdl/cpr_pkg.sv
// package: register map, field layout and carrier types of the result register bank
package cpr_pkg;

  localparam logic [7:0] ADDR_ANALOG_CONTROL       = 8'h0F;
  localparam logic [7:0] ADDR_PART_CODE            = 8'h12;
  localparam logic [7:0] ADDR_DEVICE_FLAGS         = 8'h13;
  localparam logic [7:0] ADDR_BROADBAND_COUNT_LOW  = 8'h14;
  localparam logic [7:0] ADDR_BROADBAND_COUNT_HIGH = 8'h15;
  localparam logic [7:0] ADDR_RED_COUNT_LOW        = 8'h16;
  localparam logic [7:0] ADDR_RED_COUNT_HIGH       = 8'h17;
  localparam logic [7:0] ADDR_GREEN_COUNT_LOW      = 8'h18;
  localparam logic [7:0] ADDR_GREEN_COUNT_HIGH     = 8'h19;
  localparam logic [7:0] ADDR_BLUE_COUNT_LOW       = 8'h1A;
  localparam logic [7:0] ADDR_BLUE_COUNT_HIGH      = 8'h1B;
  localparam logic [7:0] ADDR_NEARNESS_COUNT_LOW   = 8'h1C;
  localparam logic [7:0] ADDR_NEARNESS_COUNT_HIGH  = 8'h1D;

  localparam int         NUM_CHANNELS              = 5;
  localparam logic [7:0] ANALOG_CONTROL_RESET      = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE       = 8'h00;
  // arbitrary neutral identification value
  localparam logic [7:0] PART_CODE_DEFAULT         = 8'h5A;

  // flag byte bit positions
  localparam int FLAG_NEARNESS_IRQ   = 5;
  localparam int FLAG_COLOUR_IRQ     = 4;
  localparam int FLAG_NEARNESS_VALID = 1;
  localparam int FLAG_COLOUR_VALID   = 0;

  typedef enum logic [1:0] {
    CPR_DRIVE_100MA = 2'b00,
    CPR_DRIVE_50MA  = 2'b01,
    CPR_DRIVE_25MA  = 2'b10,
    CPR_DRIVE_12MA5 = 2'b11
  } cpr_led_sink_strength_t;

  typedef enum logic [1:0] {
    CPR_DIODE_RESERVED  = 2'b00,
    CPR_DIODE_BROADBAND = 2'b01,
    CPR_DIODE_SECOND    = 2'b10,
    CPR_DIODE_BOTH      = 2'b11
  } cpr_nearness_diode_select_t;

  typedef enum logic [1:0] {
    CPR_GAIN_1X  = 2'b00,
    CPR_GAIN_4X  = 2'b01,
    CPR_GAIN_16X = 2'b10,
    CPR_GAIN_60X = 2'b11
  } cpr_colour_gain_select_t;

  // control byte layout, msb first
  typedef struct packed {
    cpr_led_sink_strength_t     led_sink_strength;
    cpr_nearness_diode_select_t nearness_diode_select;
    logic [1:0]                 reserved;
    cpr_colour_gain_select_t    colour_gain_select;
  } cpr_analog_control_t;

  // register access from the serial front end
  typedef struct packed {
    logic       rd_stb;
    logic       wr_stb;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cpr_reg_req_t;

  // measurement core state shown in the flag byte
  typedef struct packed {
    logic nearness_irq_flag;
    logic colour_irq_flag;
    logic nearness_result_valid;
    logic colour_result_valid;
  } cpr_core_flags_t;

endpackage : cpr_pkg

// ### hdl/cpr_result_pair.sv
// file: one 16-bit result with its own high byte shadow latch
`timescale 1ns/1ps

module cpr_result_pair #(
  parameter int WIDTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] result,
  input  wire logic             low_read,
  output logic [7:0]            low_byte,
  output logic [7:0]            high_byte
);

  typedef struct packed {
    logic [7:0] shadow;
  } cpr_pair_state_t;

  cpr_pair_state_t state_reg;
  cpr_pair_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (low_read) begin
      state_next.shadow = result[WIDTH-1 -: 8];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign low_byte  = result[7:0];
  // later result updates never reach the latch until the next low read
  assign high_byte = state_reg.shadow;

endmodule : cpr_result_pair

// ### hdl/cpr_result_regs.sv
// file: analog control, part code, flag byte and result register bank
`timescale 1ns/1ps

// How it works
// - control bits 7:6 choose led sink strength 100, 50, 25 or 12.5 mA for codes 00 to 11.
// - control bits 1:0 choose colour gain 1x, 4x, 16x or 60x for codes 00 to 11.
// - control bits 5:4 choose the nearness diode, 01 broadband, 10 second, 11 both, 00 reserved.
// - an 8-bit part code sits at 0x12, read only, and writes leave it unchanged.
// - the flag byte at 0x13 shows internal state, is read only, and bits 7:6 and 3:2 read zero.
// - flag bit 5 shows a pending nearness interrupt and bit 4 a pending colour interrupt.
// - flag bit 1 is set once a cycle has completed since the nearness function was switched on.
// - flag bit 0 is set once the colour channels have completed an integration.
// - clear, red, green and blue results are 16-bit low/high pairs at 0x14 to 0x1B.
// - the nearness result is a 16-bit pair with low byte at 0x1C and high byte at 0x1D.
// - reading a low byte copies that result's upper eight bits into a shadow latch for the high read.
// - the high read returns the latched value even if the result changes between the two reads.
module cpr_result_regs #(
  parameter logic [7:0] PART_CODE = cpr_pkg::PART_CODE_DEFAULT,
  parameter int         RES_W     = 16
) (
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  input  wire cpr_pkg::cpr_reg_req_t        reg_req,
  output logic [7:0]                        reg_rdata,
  output logic                              reg_rvalid,
  input  wire cpr_pkg::cpr_core_flags_t     core_flags,
  input  wire logic [RES_W-1:0]             broadband_result,
  input  wire logic [RES_W-1:0]             red_result,
  input  wire logic [RES_W-1:0]             green_result,
  input  wire logic [RES_W-1:0]             blue_result,
  input  wire logic [RES_W-1:0]             nearness_result,
  output cpr_pkg::cpr_led_sink_strength_t     led_sink_strength,
  output cpr_pkg::cpr_nearness_diode_select_t nearness_diode_select,
  output cpr_pkg::cpr_colour_gain_select_t    colour_gain_select
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    cpr_pkg::cpr_analog_control_t control;
    logic [7:0]                   rdata;
    logic                         rvalid;
  } cpr_bank_state_t;

  cpr_bank_state_t state_reg;
  cpr_bank_state_t state_next;

  logic [RES_W-1:0] results   [cpr_pkg::NUM_CHANNELS];
  logic [7:0]       low_bytes [cpr_pkg::NUM_CHANNELS];
  logic [7:0]       high_bytes[cpr_pkg::NUM_CHANNELS];
  logic [cpr_pkg::NUM_CHANNELS-1:0] low_reads;
  logic [7:0]       flag_byte;

  assign results[0] = broadband_result;
  assign results[1] = red_result;
  assign results[2] = green_result;
  assign results[3] = blue_result;
  assign results[4] = nearness_result;

  // ****************************************************************
  // result pairs
  // ****************************************************************
  // one latch per pair: costs 40 flops but keeps interleaved reads safe
  genvar ch;
  generate
    for (ch = 0; ch < cpr_pkg::NUM_CHANNELS; ch++) begin : g_pair
      assign low_reads[ch] = reg_req.rd_stb &&
        (reg_req.addr == 8'(cpr_pkg::ADDR_BROADBAND_COUNT_LOW + 2 * ch));
      cpr_result_pair #(
        .WIDTH (RES_W)
      ) u_pair (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .result    (results[ch]),
        .low_read  (low_reads[ch]),
        .low_byte  (low_bytes[ch]),
        .high_byte (high_bytes[ch])
      );
    end
  endgenerate

  // ****************************************************************
  // flag byte
  // ****************************************************************
  always_comb begin
    flag_byte = 8'h00;
    flag_byte[cpr_pkg::FLAG_NEARNESS_IRQ]   = core_flags.nearness_irq_flag;
    flag_byte[cpr_pkg::FLAG_COLOUR_IRQ]     = core_flags.colour_irq_flag;
    flag_byte[cpr_pkg::FLAG_NEARNESS_VALID] = core_flags.nearness_result_valid;
    flag_byte[cpr_pkg::FLAG_COLOUR_VALID]   = core_flags.colour_result_valid;
  end

  // ****************************************************************
  // access decode
  // ****************************************************************
  always_comb begin
    state_next        = state_reg;
    state_next.rvalid = reg_req.rd_stb;
    if (reg_req.wr_stb && reg_req.addr == cpr_pkg::ADDR_ANALOG_CONTROL) begin
      // reserved bits stored as written; the host keeps them zero
      state_next.control = cpr_pkg::cpr_analog_control_t'(reg_req.wdata);
    end
    // writes to part code, flags and results fall through: read only
    if (reg_req.rd_stb) begin
      unique case (reg_req.addr)
        cpr_pkg::ADDR_ANALOG_CONTROL:       state_next.rdata = state_reg.control;
        cpr_pkg::ADDR_PART_CODE:            state_next.rdata = PART_CODE;
        cpr_pkg::ADDR_DEVICE_FLAGS:         state_next.rdata = flag_byte;
        cpr_pkg::ADDR_BROADBAND_COUNT_LOW:  state_next.rdata = low_bytes[0];
        cpr_pkg::ADDR_BROADBAND_COUNT_HIGH: state_next.rdata = high_bytes[0];
        cpr_pkg::ADDR_RED_COUNT_LOW:        state_next.rdata = low_bytes[1];
        cpr_pkg::ADDR_RED_COUNT_HIGH:       state_next.rdata = high_bytes[1];
        cpr_pkg::ADDR_GREEN_COUNT_LOW:      state_next.rdata = low_bytes[2];
        cpr_pkg::ADDR_GREEN_COUNT_HIGH:     state_next.rdata = high_bytes[2];
        cpr_pkg::ADDR_BLUE_COUNT_LOW:       state_next.rdata = low_bytes[3];
        cpr_pkg::ADDR_BLUE_COUNT_HIGH:      state_next.rdata = high_bytes[3];
        cpr_pkg::ADDR_NEARNESS_COUNT_LOW:   state_next.rdata = low_bytes[4];
        cpr_pkg::ADDR_NEARNESS_COUNT_HIGH:  state_next.rdata = high_bytes[4];
        default:                            state_next.rdata = cpr_pkg::UNMAPPED_READ_VALUE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg         <= '0;
      state_reg.control <= cpr_pkg::cpr_analog_control_t'(cpr_pkg::ANALOG_CONTROL_RESET);
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign reg_rdata             = state_reg.rdata;
  assign reg_rvalid            = state_reg.rvalid;
  assign led_sink_strength     = state_reg.control.led_sink_strength;
  assign nearness_diode_select = state_reg.control.nearness_diode_select;
  assign colour_gain_select    = state_reg.control.colour_gain_select;

endmodule : cpr_result_regs

// ### sim/cpr_result_regs_checker.sv
// checker: port relations of the result register bank
`timescale 1ns/1ps
module cpr_result_regs_checker #(
  parameter logic [7:0] PART_CODE = cpr_pkg::PART_CODE_DEFAULT,
  parameter int         RES_W     = 16
) (
  input wire logic                                core_clk,
  input wire logic                                rst_n,
  input wire cpr_pkg::cpr_reg_req_t               reg_req,
  input wire logic [7:0]                          reg_rdata,
  input wire logic                                reg_rvalid,
  input wire cpr_pkg::cpr_core_flags_t            core_flags,
  input wire logic [RES_W-1:0]                    broadband_result,
  input wire logic [RES_W-1:0]                    red_result,
  input wire logic [RES_W-1:0]                    green_result,
  input wire logic [RES_W-1:0]                    blue_result,
  input wire logic [RES_W-1:0]                    nearness_result,
  input wire cpr_pkg::cpr_led_sink_strength_t     led_sink_strength,
  input wire cpr_pkg::cpr_nearness_diode_select_t nearness_diode_select,
  input wire cpr_pkg::cpr_colour_gain_select_t    colour_gain_select
);
  // ****
  // shadow model, one latch per channel
  // ****
  logic [7:0]       sh_reg [5];
  logic [RES_W-1:0] res    [5];
  logic [2:0]       idx;
  logic [7:0]       lo_exp;
  logic [7:0]       hi_exp;
  wire rd = reg_req.rd_stb;
  wire wc = reg_req.wr_stb && reg_req.addr == cpr_pkg::ADDR_ANALOG_CONTROL;
  wire [7:0] ad = reg_req.addr;
  wire lo_rd = rd && ad inside {[8'h14:8'h1C]} && !ad[0];
  wire hi_rd = rd && ad inside {[8'h15:8'h1D]} && ad[0];
  wire [5:0] ctl = {led_sink_strength, nearness_diode_select, colour_gain_select};
  assign res = '{broadband_result, red_result, green_result, blue_result, nearness_result};
  assign idx = 3'((ad - 8'h14) >> 1);
  assign lo_exp = (idx < 3'd5) ? res[idx][7:0] : 8'h00;
  assign hi_exp = (idx < 3'd5) ? sh_reg[idx] : 8'h00;
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 5; i++) begin
      if (!rst_n) sh_reg[i] <= 8'h00;
      else if (lo_rd && idx == 3'(i)) sh_reg[i] <= res[i][RES_W-1 -: 8];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_read_answered: assert property (rd |=> reg_rvalid)
    else $error("read not answered");
  a_no_stray_valid: assert property (!rd |=> !reg_rvalid && $stable(reg_rdata))
    else $error("stray read answer");
  a_part_code_fixed: assert property (rd && ad == 8'h12 |=> reg_rdata == PART_CODE)
    else $error("part code wrong");
  a_flag_byte_live: assert property (rd && ad == 8'h13 |=> reg_rdata ==
    {2'b00, $past(core_flags[3:2]), 2'b00, $past(core_flags[1:0])}) else $error("flags wrong");
  a_ctrl_write_lands: assert property (wc |=> ctl ==
    {$past(reg_req.wdata[7:4]), $past(reg_req.wdata[1:0])}) else $error("control wrong");
  a_ctrl_holds: assert property (!wc |=> $stable(ctl))
    else $error("control moved");
  a_low_byte_live: assert property (lo_rd |=> reg_rdata == $past(lo_exp))
    else $error("low byte wrong");
  a_high_from_shadow: assert property (hi_rd |=> reg_rdata == $past(hi_exp))
    else $error("high byte wrong");
  a_unmapped_zero: assert property (rd && (ad < 8'h0F || ad inside {8'h10, 8'h11} || ad > 8'h1D)
    |=> reg_rdata == 8'h00) else $error("unmapped read nonzero");
  c_word_read: cover property (lo_rd ##1 hi_rd);
  c_ctrl_write: cover property (wc);
  c_flag_read: cover property (rd && ad == 8'h13 && core_flags[3]);
endmodule : cpr_result_regs_checker

// ### sim/cpr_host_model.sv
// partner: host issuing byte reads, byte writes and word reads
`timescale 1ns/1ps
module cpr_host_model (
  input  wire logic             core_clk,
  input  wire logic [7:0]       reg_rdata,
  input  wire logic             reg_rvalid,
  output cpr_pkg::cpr_reg_req_t reg_req
);
  initial reg_req = 18'h00000;
  // idle fields show the inverse so stale values never pass as valid
  task automatic idle();
    reg_req.rd_stb = 1'b0;
    reg_req.wr_stb = 1'b0;
    reg_req.addr = ~reg_req.addr;
    reg_req.wdata = ~reg_req.wdata;
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 reg_req.wr_stb = 1'b1;
    reg_req.addr = a;
    reg_req.wdata = (a == 8'h0F) ? {d[7:4], 2'b00, d[1:0]} : d;
    @(posedge core_clk);
    #1 idle();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    int n;
    @(posedge core_clk);
    #1 reg_req.rd_stb = 1'b1;
    reg_req.addr = a;
    @(posedge core_clk);
    #1 idle();
    n = 0;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(posedge core_clk);
      #1 n++;
    end
    ok = (reg_rvalid === 1'b1);
    d = reg_rdata;
  endtask : rd
  // low then high on back-to-back cycles keeps the pair coherent
  task automatic word(input logic [7:0] a, output logic [16:0] w);
    @(posedge core_clk);
    #1 reg_req.rd_stb = 1'b1;
    reg_req.addr = a;
    @(posedge core_clk);
    #1 w[7:0] = reg_rdata;
    w[16] = reg_rvalid;
    reg_req.addr = a + 8'h01;
    @(posedge core_clk);
    #1 idle();
    w[15:8] = reg_rdata;
  endtask : word
endmodule : cpr_host_model

// ### sim/cpr_result_regs_tb_top.sv
// testbench: register sweep, then flag, shadow and reset cases
`timescale 1ns/1ps
module cpr_result_regs_tb_top;
  logic                  core_clk = 1'b0;
  logic                  rst_n    = 1'b0;
  cpr_pkg::cpr_core_flags_t flags = 4'h0;
  cpr_pkg::cpr_reg_req_t req;
  logic [15:0]           res [5] = '{16'h1234, 16'hA5C3, 16'h0FF0, 16'hBEEF, 16'h7E81};
  logic [7:0]            rdata;
  logic [7:0]            d;
  logic                  rvalid;
  logic                  ok;
  logic [16:0]           w;
  logic [5:0]            ctl;
  int                    failures = 0;
  int                    check_count = 0;
  // wr, addr, data; part code 8'hC6 is an arbitrary value
  logic [16:0] rows [12] = '{17'h10FF3, 17'h10FA2, 17'h10F51, 17'h10F00, 17'h012C6,
    17'h01434, 17'h016C3, 17'h018F0, 17'h01AEF, 17'h01C81, 17'h01000, 17'h01E00};
  cpr_host_model host (.core_clk(core_clk), .reg_rdata(rdata), .reg_rvalid(rvalid), .reg_req(req));
  cpr_result_regs #(.PART_CODE(8'hC6)) dut (.core_clk(core_clk), .rst_n(rst_n), .reg_req(req),
    .reg_rdata(rdata), .reg_rvalid(rvalid), .core_flags(flags), .broadband_result(res[0]),
    .red_result(res[1]), .green_result(res[2]), .blue_result(res[3]), .nearness_result(res[4]),
    .led_sink_strength(ctl[5:4]), .nearness_diode_select(ctl[3:2]), .colour_gain_select(ctl[1:0]));
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h wanted %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  initial forever #10 core_clk = ~core_clk;
  // ****
  // main sequence
  // ****
  initial begin
    repeat (12) @(posedge core_clk);
    #1 rst_n = 1'b1;
    check(17'({rdata, ctl}), 17'h0);
    host.rd(8'h15, d, ok);
    check({8'h0, ok, d}, 17'h00100);
    foreach (rows[i]) begin
      if (rows[i][16]) begin
        host.wr(8'h0F, rows[i][7:0]);
        check(17'(ctl), 17'({rows[i][7:4], rows[i][1:0]}));
      end
      host.rd(rows[i][15:8], d, ok);
      check({8'h0, ok, d}, {9'h001, rows[i][7:0]});
    end
    $display("sweep done");
    host.wr(8'h12, 8'h00);
    host.rd(8'h12, d, ok);
    check({8'h0, ok, d}, 17'h001C6);
    for (int f = 0; f < 16; f++) begin
      flags = f[3:0];
      host.rd(8'h13, d, ok);
      check({8'h0, ok, d}, {9'h001, 2'b00, f[3:2], 2'b00, f[1:0]});
    end
    $display("flags done");
    host.rd(8'h16, d, ok);
    res[1] = 16'h5A5A;
    host.rd(8'h14, d, ok);
    host.rd(8'h17, d, ok);
    check({8'h0, ok, d}, 17'h001A5);
    host.rd(8'h15, d, ok);
    check({8'h0, ok, d}, 17'h00112);
    host.word(8'h1C, w);
    check(w, 17'h17E81);
    host.word(8'h18, w);
    check(w, 17'h10FF0);
    host.word(8'h1A, w);
    check(w, 17'h1BEEF);
    host.word(8'h16, w);
    check(w, 17'h15A5A);
    $display("shadow done");
    // nonzero control first, so the reset below has something to clear
    host.wr(8'h0F, 8'hE1);
    check(17'(ctl), 17'h39);
    rst_n = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 rst_n = 1'b1;
    check(17'({rdata, rvalid, ctl}), 17'h0);
    host.rd(8'h17, d, ok);
    check(17'({ctl, ok, d}), 17'h00100);
    $display("reset done");
    close_out();
  end
endmodule : cpr_result_regs_tb_top
bind cpr_result_regs cpr_result_regs_checker #(.PART_CODE(PART_CODE), .RES_W(RES_W)) chk (
  .core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .core_flags(core_flags), .broadband_result(broadband_result),
  .red_result(red_result), .green_result(green_result), .blue_result(blue_result),
  .nearness_result(nearness_result), .led_sink_strength(led_sink_strength),
  .nearness_diode_select(nearness_diode_select), .colour_gain_select(colour_gain_select));
